// >>> hdl/pbd_map.svh
// Constants for the pulse-batch dosing controller.
`ifndef PBD_MAP_SVH
`define PBD_MAP_SVH
`define PBD_CLK_HZ 200000000
`define PBD_TIMEOUT_S 20
// Cycles per millisecond; the products below stay inside 32 bits.
`define PBD_CLK_PER_MS (`PBD_CLK_HZ / 1000)
// The idle timeout needs the full unsigned 32-bit range.
`define PBD_TIMEOUT_CYC (`PBD_TIMEOUT_S * `PBD_CLK_PER_MS * 32'h000003E8)
`define PBD_HOLD_MS 2000
`define PBD_HOLD_CYC (`PBD_HOLD_MS * `PBD_CLK_PER_MS)
`define PBD_TENTH_MS 100
`define PBD_TENTH_CYC (`PBD_TENTH_MS * `PBD_CLK_PER_MS)
`define PBD_DEF_COUNT 16'h0001
`define PBD_DEF_SPEED 10'h3E8
`define PBD_DEF_ONTIME 16'h0019
`define PBD_DEF_UNIT_MIN 1'b0
`define PBD_REG_CTRL 32'h00000000
`define PBD_REG_ONTIME 32'h00000004
`define PBD_REG_COUNT 32'h00000008
`define PBD_REG_SPEED 32'h0000000C
`define PBD_REG_STATUS 32'h00000010
`define PBD_REG_IRQ_STAT 32'h00000014
`define PBD_REG_IRQ_MASK 32'h00000018
`define PBD_CTRL_START 0
`define PBD_CTRL_STOP 1
`define PBD_CTRL_MODE_REQ 2
`define PBD_CTRL_FLOW_EN 3
`define PBD_IRQ_BATCH 0
`define PBD_IRQ_DONE 1
`define PBD_IRQ_RUPT 2
`define PBD_IRQ_FLOW 3
`endif

// >>> hdl/pbd_pkg.sv
// Types shared by the pulse-batch dosing controller.
package pbd_pkg;
  typedef enum logic [2:0] {MENU_RUN, MENU_ONTIME, MENU_UNIT, MENU_COUNT, MENU_SPEED} pbd_menu_type;
  typedef enum logic [1:0] {VIEW_SPEED, VIEW_PULSES, VIEW_MA} pbd_view_type;
endpackage

// >>> hdl/pbd_btn_if.sv
// Interface carrying cleaned button events from the key scanner.
`timescale 1ns/1ps
`default_nettype none
interface pbd_btn_if;
  logic menu_short;
  logic menu_long;
  logic up_press;
  logic down_press;
  logic any_press;
  modport src (output menu_short, output menu_long, output up_press, output down_press,
    output any_press);
  modport dst (input menu_short, input menu_long, input up_press, input down_press,
    input any_press);
endinterface
`default_nettype wire

// >>> hdl/pbd_keys.sv
// Button synchroniser and press classifier.
`timescale 1ns/1ps
`default_nettype none
`include "pbd_map.svh"
module pbd_keys
  import pbd_pkg::*;
#(
  parameter int HOLD_CYC = `PBD_HOLD_CYC
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic menu_pin,
  input wire logic up_pin,
  input wire logic down_pin,
  pbd_btn_if.src btn
);
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic [2:0] prev_q;
  logic [31:0] hold_q;
  logic long_done_q;

  // Two-flop synchroniser for the three buttons.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      prev_q <= 3'h0;
    end
    else
    begin
      sync1_q <= {down_pin, up_pin, menu_pin};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // Menu hold timer; a long hold fires once while held, a short one on release.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      hold_q <= 32'h0;
      long_done_q <= 1'b0;
      btn.menu_long <= 1'b0;
      btn.menu_short <= 1'b0;
    end
    else
    begin
      btn.menu_long <= 1'b0;
      btn.menu_short <= 1'b0;
      if (sync2_q[0])
      begin
        if (!long_done_q && hold_q >= 32'(HOLD_CYC - 1))
        begin
          btn.menu_long <= 1'b1;
          long_done_q <= 1'b1;
        end
        else
          hold_q <= hold_q + 32'h1;
      end
      else
      begin
        if (prev_q[0] && !long_done_q)
          btn.menu_short <= 1'b1;
        hold_q <= 32'h0;
        long_done_q <= 1'b0;
      end
    end
  end

  // Arrow presses and the activity pulse are rising edges.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      btn.up_press <= 1'b0;
      btn.down_press <= 1'b0;
      btn.any_press <= 1'b0;
    end
    else
    begin
      btn.up_press <= sync2_q[1] & ~prev_q[1];
      btn.down_press <= sync2_q[2] & ~prev_q[2];
      btn.any_press <= |(sync2_q & ~prev_q);
    end
  end
endmodule
`default_nettype wire

// >>> hdl/pbd_top.sv
// Pulse-batch dosing controller with menu, display views, alarm relay and Wishbone slave.
// How it works
// [RULE1] Menu hold in batch mode enters setup, flashes.
// [RULE2] First step edits on-time; menu stores it.
// [RULE3] Second step toggles minutes/seconds with arrows.
// [RULE4] Twenty idle seconds leave menu; presses restart.
// [RULE5] Timeout keeps all edited values.
// [RULE6] Step edits trigger pulse count.
// [RULE7] Step edits speed; motor runs it on trigger.
// [RULE8] Long menu hold exits setup to run.
// [RULE9] Short menu press cycles speed, pulses, mA views.
// [RULE10] Relay energises on rupture or flow fault.
// [RULE11] Flow fault counts only when sensor enabled.
// [RULE12] Rupture stops motor, closes relay, flashes alarm.
// [RULE13] Mode change refused while motor runs.
// [RULE14] Defaults: one pulse, full speed, 2.5 s.
// [RULE15] On-time end stops motor, clears pulse count.
// [RULE16] Source gives clean, slow, separated pulses.
//
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "pbd_map.svh"
module pbd_top
  import pbd_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `PBD_TIMEOUT_CYC,
  parameter int HOLD_CYC = `PBD_HOLD_CYC,
  parameter int TENTH_CYC = `PBD_TENTH_CYC
)
(
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [31:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic MENU_BTN,
  input wire logic UP_BTN,
  input wire logic DOWN_BTN,
  input wire logic PULSE_IN,
  input wire logic MEMBRANE_RUPTURE_DETECT,
  input wire logic FLOW_CONFIRM_SENSOR_FAULT,
  input wire logic FLOW_CONFIRM_SENSOR_PRESENT,
  input wire logic BATCH_MODE_SEL,
  output logic MOTOR_RUN,
  output logic [9:0] MOTOR_SPEED,
  output logic ALARM_RELAY,
  output logic ONTIME_ICON_FLASH,
  output logic RUPTURE_FLASH,
  output logic [1:0] DISPLAY_VIEW,
  output logic [2:0] MENU_STEP,
  output logic [15:0] PULSE_COUNT,
  output logic BATCH_MODE,
  output logic IRQ
);
  pbd_btn_if btn ();
  pbd_menu_type menu_q;
  pbd_view_type view_q;
  logic [15:0] ontime_q;
  logic unit_min_q;
  logic [15:0] count_q;
  logic [9:0] speed_q;
  logic [31:0] idle_q;
  logic [31:0] tick_q;
  logic [31:0] left_q;
  logic [15:0] pulses_q;
  logic [2:0] ps_q;
  logic [1:0] ar_q;
  logic flow_en_q;
  logic mode_q;
  logic run_q;
  logic [3:0] irq_stat_q;
  logic [3:0] irq_mask_q;
  logic in_menu;
  logic pulse_rise;
  logic rupt;
  logic flow_fault;
  logic tick_end;
  logic batch_trig;
  logic batch_end;
  logic wb_req;
  logic wr_ctrl;
  logic [3:0] irq_ev;

  // Saturating up/down adjust used by every numeric step.
  function automatic logic [15:0] step_val(input logic [15:0] v, input logic up,
    input logic dn, input logic [15:0] lo, input logic [15:0] hi);
    logic [15:0] r;
    r = v;
    if (up && v < hi)
      r = v + 16'h1;
    else if (dn && v > lo)
      r = v - 16'h1;
    return r;
  endfunction

  pbd_keys #(.HOLD_CYC(HOLD_CYC)) u_keys (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .menu_pin(MENU_BTN),
    .up_pin(UP_BTN),
    .down_pin(DOWN_BTN),
    .btn(btn)
  );

  // Synchronisers for the pulse input and the membrane rupture sensor.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESETN)
    begin
      ps_q <= 3'h0;
      ar_q <= 2'h0;
    end
    else
    begin
      ps_q <= {ps_q[1:0], PULSE_IN};
      ar_q <= {ar_q[0], MEMBRANE_RUPTURE_DETECT};
    end
  end

  logic [1:0] fl_q;
  logic [1:0] fp_q;
  logic [1:0] bm_q;
  // Second group of synchronisers for sensor state and mode pin.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESETN)
    begin
      fl_q <= 2'h0;
      fp_q <= 2'h0;
      bm_q <= 2'h0;
    end
    else
    begin
      fl_q <= {fl_q[0], FLOW_CONFIRM_SENSOR_FAULT};
      fp_q <= {fp_q[0], FLOW_CONFIRM_SENSOR_PRESENT};
      bm_q <= {bm_q[0], BATCH_MODE_SEL};
    end
  end

  assign in_menu = (menu_q != MENU_RUN);
  assign pulse_rise = ps_q[1] & ~ps_q[2]; // RULE16
  assign rupt = ar_q[1];
  assign flow_fault = fl_q[1] & fp_q[1] & flow_en_q; // RULE11
  assign tick_end = (tick_q >= 32'(TENTH_CYC - 1));
  assign batch_trig = mode_q && !run_q && !rupt && pulse_rise && (pulses_q + 16'h1 >= count_q);
  assign batch_end = run_q && tick_end && (left_q <= 32'h1);
  assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr_ctrl = wb_req && WB_WE_I && WB_SEL_I[0] && (WB_ADR_I == `PBD_REG_CTRL);

  // Mode selection; only accepted while the motor is stopped.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESETN)
      mode_q <= 1'b0;
    else if (!run_q && !in_menu && (mode_q != bm_q[1])) // RULE13
      mode_q <= bm_q[1];
  end

  // Setup menu walk, inactivity timeout and long-hold exit.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESETN)
      menu_q <= MENU_RUN;
    else if (in_menu && (btn.menu_long || idle_q >= 32'(TIMEOUT_CYC - 1)))
      menu_q <= MENU_RUN; // RULE4 RULE5 RULE8
    else
    begin
      case (menu_q)
        MENU_RUN: if (btn.menu_long && mode_q && !run_q) menu_q <= MENU_ONTIME; // RULE1
        MENU_ONTIME: if (btn.menu_short) menu_q <= MENU_UNIT; // RULE2
        MENU_UNIT: if (btn.menu_short) menu_q <= MENU_COUNT; // RULE3
        MENU_COUNT: if (btn.menu_short) menu_q <= MENU_SPEED; // RULE6
        MENU_SPEED: if (btn.menu_short) menu_q <= MENU_ONTIME; // RULE7
        default: menu_q <= MENU_RUN;
      endcase
    end
  end

  // Idle counter restarted by every press while in the menu.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESETN || !in_menu || btn.any_press || btn.menu_short || btn.menu_long)
      idle_q <= 32'h0;
    else
      idle_q <= idle_q + 32'h1; // RULE4
  end

  // Settings are edited in place, so any exit keeps them.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESETN)
    begin
      ontime_q <= `PBD_DEF_ONTIME; // RULE14
      unit_min_q <= `PBD_DEF_UNIT_MIN;
      count_q <= `PBD_DEF_COUNT;
      speed_q <= `PBD_DEF_SPEED;
    end
    else
    begin
      case (menu_q)
        MENU_ONTIME: ontime_q <= step_val(ontime_q, btn.up_press, btn.down_press,
          16'h0001, 16'hFFFF); // RULE2 RULE5
        MENU_UNIT: if (btn.up_press || btn.down_press) unit_min_q <= ~unit_min_q; // RULE3
        MENU_COUNT: count_q <= step_val(count_q, btn.up_press, btn.down_press,
          16'h0001, 16'hFFFF); // RULE6
        MENU_SPEED: speed_q <= 10'(step_val({6'h00, speed_q}, btn.up_press,
          btn.down_press, 16'h0001, 16'h03E8)); // RULE7
        default: ;
      endcase
    end
  end

  // Runtime view cycling on short menu presses.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESETN)
      view_q <= VIEW_SPEED;
    else if (!in_menu && btn.menu_short)
    begin
      case (view_q)
        VIEW_SPEED: view_q <= VIEW_PULSES; // RULE9
        VIEW_PULSES: view_q <= VIEW_MA;
        default: view_q <= VIEW_SPEED;
      endcase
    end
  end

  // Pulse counter, cleared when a batch ends.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESETN || batch_end)
      pulses_q <= 16'h0; // RULE15
    else if (mode_q && !run_q && pulse_rise && !batch_trig)
      pulses_q <= pulses_q + 16'h1;
  end

  // Motor run state; on-time counted in tenths of seconds or minutes.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESETN)
    begin
      run_q <= 1'b0;
      left_q <= 32'h0;
      tick_q <= 32'h0;
    end
    else if (rupt || batch_end || (wr_ctrl && WB_DAT_I[`PBD_CTRL_STOP]))
    begin
      run_q <= 1'b0; // RULE12 RULE15
      tick_q <= 32'h0;
    end
    else if (batch_trig)
    begin
      run_q <= 1'b1; // RULE7
      left_q <= unit_min_q ? {16'h0000, ontime_q} * 32'h00000258 : {16'h0000, ontime_q};
      tick_q <= 32'h0;
    end
    else if (run_q)
    begin
      tick_q <= tick_end ? 32'h0 : tick_q + 32'h1;
      if (tick_end)
        left_q <= left_q - 32'h1;
    end
  end

  // Registered outputs.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESETN)
    begin
      MOTOR_RUN <= 1'b0;
      MOTOR_SPEED <= 10'h000;
      ALARM_RELAY <= 1'b0;
      ONTIME_ICON_FLASH <= 1'b0;
      RUPTURE_FLASH <= 1'b0;
      DISPLAY_VIEW <= 2'h0;
      MENU_STEP <= 3'h0;
      PULSE_COUNT <= 16'h0;
      BATCH_MODE <= 1'b0;
      IRQ <= 1'b0;
    end
    else
    begin
      MOTOR_RUN <= run_q && !rupt; // RULE12
      MOTOR_SPEED <= run_q ? speed_q : 10'h000; // RULE7
      ALARM_RELAY <= rupt || flow_fault; // RULE10
      ONTIME_ICON_FLASH <= in_menu; // RULE1
      RUPTURE_FLASH <= rupt; // RULE12
      DISPLAY_VIEW <= view_q;
      MENU_STEP <= menu_q;
      PULSE_COUNT <= pulses_q;
      BATCH_MODE <= mode_q;
      IRQ <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Sticky event bits; read clears, a fresh event wins.
  assign irq_ev = {flow_fault, rupt, batch_end, batch_trig};
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESETN)
      irq_stat_q <= 4'h0;
    else if (wb_req && !WB_WE_I && WB_ADR_I == `PBD_REG_IRQ_STAT)
      irq_stat_q <= irq_ev;
    else
      irq_stat_q <= irq_stat_q | irq_ev;
  end

  // Wishbone slave: one-cycle ack, writable mask and control.
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESETN)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
      irq_mask_q <= 4'h0;
      flow_en_q <= 1'b0;
    end
    else
    begin
      WB_ACK_O <= wb_req;
      if (wb_req && WB_WE_I && WB_SEL_I[0])
      begin
        if (WB_ADR_I == `PBD_REG_IRQ_MASK)
          irq_mask_q <= WB_DAT_I[3:0];
        else if (WB_ADR_I == `PBD_REG_CTRL)
          flow_en_q <= WB_DAT_I[`PBD_CTRL_FLOW_EN]; // RULE11
      end
      if (wb_req && !WB_WE_I)
      begin
        if (WB_ADR_I == `PBD_REG_CTRL)
          WB_DAT_O <= {28'h0, flow_en_q, 3'h0};
        else if (WB_ADR_I == `PBD_REG_ONTIME)
          WB_DAT_O <= {15'h0, unit_min_q, ontime_q};
        else if (WB_ADR_I == `PBD_REG_COUNT)
          WB_DAT_O <= {pulses_q, count_q};
        else if (WB_ADR_I == `PBD_REG_SPEED)
          WB_DAT_O <= {22'h0, speed_q};
        else if (WB_ADR_I == `PBD_REG_STATUS)
          WB_DAT_O <= {24'h0, mode_q, run_q, rupt, flow_fault, 1'b0, menu_q};
        else if (WB_ADR_I == `PBD_REG_IRQ_STAT)
          WB_DAT_O <= {28'h0, irq_stat_q};
        else if (WB_ADR_I == `PBD_REG_IRQ_MASK)
          WB_DAT_O <= {28'h0, irq_mask_q};
        else
          WB_DAT_O <= 32'h0;
      end
    end
  end

  // The motor never runs while the rupture alarm stands.
  AST_RUPT_STOP: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    rupt |=> !MOTOR_RUN && ALARM_RELAY) else $error("motor ran during rupture"); // RULE12
  // Relay follows rupture or an enabled flow fault.
  AST_RELAY: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (rupt || flow_fault) |=> ALARM_RELAY) else $error("relay not energised"); // RULE10
  // No relay without alarm cause.
  AST_FLOW_GATE: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (!rupt && !flow_en_q) |=> !ALARM_RELAY) else $error("relay without enabled cause"); // RULE11
  // Mode never changes while running.
  AST_MODE_HOLD: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    run_q |=> $stable(mode_q)) else $error("mode changed while running"); // RULE13
  // Trigger starts the motor at the stored speed.
  sequence s_trig;
    batch_trig && !rupt;
  endsequence
  AST_START: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    s_trig |=> run_q ##1 (MOTOR_SPEED == speed_q)) else $error("batch did not start"); // RULE7
  // End of batch clears pulses and stops.
  AST_END: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    batch_end |=> !run_q && pulses_q == 16'h0) else $error("batch end not clean"); // RULE15
  // Long hold in menu returns to run.
  AST_EXIT: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (in_menu && btn.menu_long) |=> menu_q == MENU_RUN) else $error("long hold kept menu"); // RULE8
  // Short press in the run screen advances the view.
  AST_VIEW: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (!in_menu && btn.menu_short && view_q == VIEW_SPEED) |=> view_q == VIEW_PULSES)
    else $error("view did not advance"); // RULE9
  // Entry into setup flashes the icon.
  AST_ENTER: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (!in_menu && btn.menu_long && mode_q && !run_q) |=> ##1 ONTIME_ICON_FLASH)
    else $error("setup entry not shown"); // RULE1
endmodule
`default_nettype wire

// >>> bench/pbd_pulse_src.sv
// Model of the external pulse source that triggers dosing batches.
`timescale 1ns/1ps
`default_nettype none
module pbd_pulse_src
#(
  parameter int WIDTH = 4
)
(
  input wire logic clk,
  input wire logic fire,
  output logic pulse
);
  int cnt_q = 0;
  // Each request made while no pulse is out gives one clean pulse, held long enough to be seen once.
  always_ff @(posedge clk)
  begin
    if (fire && cnt_q == 0)
      cnt_q <= WIDTH;
    else if (cnt_q > 0)
      cnt_q <= cnt_q - 1;
  end
  assign pulse = (cnt_q > 0);
endmodule
`default_nettype wire

// >>> bench/pbd_top_tb_top.sv
// Self-checking bench for the pulse-batch dosing controller.
`timescale 1ns/1ps
`default_nettype none
module pbd_top_tb_top;
  logic CORE_CLK, RESETN, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, fire, PULSE_IN;
  logic [31:0] WB_ADR_I, WB_DAT_I, WB_DAT_O, rnd;
  logic [3:0] WB_SEL_I;
  logic MENU_BTN, UP_BTN, DOWN_BTN, MEMBRANE_RUPTURE_DETECT, FLOW_CONFIRM_SENSOR_FAULT;
  logic FLOW_CONFIRM_SENSOR_PRESENT, BATCH_MODE_SEL, MOTOR_RUN, ALARM_RELAY;
  logic ONTIME_ICON_FLASH, RUPTURE_FLASH, BATCH_MODE, IRQ;
  logic [9:0] MOTOR_SPEED;
  logic [1:0] DISPLAY_VIEW;
  logic [2:0] MENU_STEP;
  logic [15:0] PULSE_COUNT;
  logic [31:0] exp_q[$];
  int num_errors = 0;
  int n_checks = 0;
  pbd_top #(.TIMEOUT_CYC(200), .HOLD_CYC(20), .TENTH_CYC(10)) dut (.CORE_CLK(CORE_CLK),
    .RESETN(RESETN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .MENU_BTN(MENU_BTN), .UP_BTN(UP_BTN), .DOWN_BTN(DOWN_BTN),
    .PULSE_IN(PULSE_IN), .MEMBRANE_RUPTURE_DETECT(MEMBRANE_RUPTURE_DETECT),
    .FLOW_CONFIRM_SENSOR_FAULT(FLOW_CONFIRM_SENSOR_FAULT),
    .FLOW_CONFIRM_SENSOR_PRESENT(FLOW_CONFIRM_SENSOR_PRESENT),
    .BATCH_MODE_SEL(BATCH_MODE_SEL), .MOTOR_RUN(MOTOR_RUN), .MOTOR_SPEED(MOTOR_SPEED),
    .ALARM_RELAY(ALARM_RELAY), .ONTIME_ICON_FLASH(ONTIME_ICON_FLASH),
    .RUPTURE_FLASH(RUPTURE_FLASH), .DISPLAY_VIEW(DISPLAY_VIEW), .MENU_STEP(MENU_STEP),
    .PULSE_COUNT(PULSE_COUNT), .BATCH_MODE(BATCH_MODE), .IRQ(IRQ));
  pbd_pulse_src src (.clk(CORE_CLK), .fire(fire), .pulse(PULSE_IN));
  // The 200 MHz core clock.
  initial
  begin
    CORE_CLK = 1'b0;
    forever #2.5 CORE_CLK = ~CORE_CLK;
  end
  // Prints the verdict and ends the run.
  task automatic finish_test();
    if (num_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Compares one value and counts the outcome.
  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask
  // Next value of the xorshift generator.
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  // One classic Wishbone cycle; a read notes its expected data first.
  task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    if (!we)
      exp_q.push_back(d);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= a;
    WB_DAT_I <= we ? d : 32'h00000000;
    WB_SEL_I <= 4'hF;
    do
    begin
      @(posedge CORE_CLK);
      n++;
    end while (WB_ACK_O !== 1'b1 && n < 50);
    if (WB_ACK_O !== 1'b1)
    begin
      chk("bus ack timeout", 32'h00000001, 32'h00000000);
      finish_test();
    end
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    WB_WE_I <= 1'b0;
    @(posedge CORE_CLK);
  endtask
  // Read data is taken at the acknowledge edge and matched to the oldest note.
  always @(posedge CORE_CLK)
  begin
    if (WB_ACK_O === 1'b1 && WB_WE_I === 1'b0 && exp_q.size() > 0)
      chk("read data", exp_q.pop_front(), WB_DAT_O);
  end
  // Lets the given number of cycles pass.
  task automatic cyc(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask
  // Holds one button for the given cycles, then waits for it to settle.
  task automatic press(input int b, input int n);
    case (b)
      0: MENU_BTN <= 1'b1;
      1: UP_BTN <= 1'b1;
      default: DOWN_BTN <= 1'b1;
    endcase
    cyc(n);
    MENU_BTN <= 1'b0;
    UP_BTN <= 1'b0;
    DOWN_BTN <= 1'b0;
    cyc(6);
  endtask
  // Waits, bounded, until the motor run output reaches the given level.
  task automatic wait_run(input logic v, input int lim);
    int n;
    n = 0;
    while (MOTOR_RUN !== v && n < lim)
    begin
      @(posedge CORE_CLK);
      n++;
    end
    if (MOTOR_RUN !== v)
    begin
      chk("motor run wait", 32'(v), 32'(MOTOR_RUN));
      finish_test();
    end
  endtask
  // Main sequence.
  initial
  begin
    {WB_CYC_I, WB_STB_I, WB_WE_I, fire, MENU_BTN, UP_BTN, DOWN_BTN} = 7'h00;
    {MEMBRANE_RUPTURE_DETECT, FLOW_CONFIRM_SENSOR_FAULT, FLOW_CONFIRM_SENSOR_PRESENT} = 3'h0;
    BATCH_MODE_SEL = 1'b0;
    WB_ADR_I = 32'h00000000;
    WB_DAT_I = 32'h00000000;
    WB_SEL_I = 4'h0;
    RESETN = 1'b0;
    rnd = 32'hFEE43146;
    cyc(20);
    RESETN <= 1'b1;
    cyc(1);
    wb(1'b0, 32'h00000004, 32'h00000019);
    wb(1'b0, 32'h00000008, 32'h00000001);
    wb(1'b0, 32'h0000000C, 32'h000003E8);
    rnd = xs(rnd);
    wb(1'b1, 32'h00000040, rnd);
    wb(1'b0, 32'h00000040, 32'h00000000);
    wb(1'b1, 32'h00000018, 32'h00000003);
    BATCH_MODE_SEL <= 1'b1;
    cyc(8);
    chk("batch mode", 32'h1, 32'(BATCH_MODE));
    fire <= 1'b1;
    cyc(1);
    fire <= 1'b0;
    wait_run(1'b1, 20);
    cyc(2);
    chk("motor speed", 32'h3E8, 32'(MOTOR_SPEED));
    BATCH_MODE_SEL <= 1'b0;
    cyc(8);
    chk("mode held while running", 32'h1, 32'(BATCH_MODE));
    BATCH_MODE_SEL <= 1'b1;
    wait_run(1'b0, 400);
    cyc(2);
    chk("pulses cleared", 32'h0, 32'(PULSE_COUNT));
    chk("irq raised", 32'h1, 32'(IRQ));
    wb(1'b0, 32'h00000014, 32'h00000003);
    cyc(2);
    chk("irq cleared", 32'h0, 32'(IRQ));
    for (int i = 1; i <= 3; i++)
    begin
      press(0, 4);
      chk("display view", 32'(i % 3), 32'(DISPLAY_VIEW));
    end
    press(0, 26);
    chk("menu step", 32'h1, 32'(MENU_STEP));
    chk("on-time flash", 32'h1, 32'(ONTIME_ICON_FLASH));
    press(1, 4);
    wb(1'b0, 32'h00000004, 32'h0000001A);
    press(0, 4);
    chk("menu step", 32'h2, 32'(MENU_STEP));
    press(2, 4);
    wb(1'b0, 32'h00000004, 32'h0001001A);
    press(0, 4);
    chk("menu step", 32'h3, 32'(MENU_STEP));
    press(1, 4);
    wb(1'b0, 32'h00000008, 32'h00000002);
    press(0, 4);
    chk("menu step", 32'h4, 32'(MENU_STEP));
    cyc(170);
    chk("menu held", 32'h4, 32'(MENU_STEP));
    cyc(60);
    chk("menu timeout", 32'h0, 32'(MENU_STEP));
    wb(1'b0, 32'h00000004, 32'h0001001A);
    wb(1'b0, 32'h00000008, 32'h00000002);
    press(0, 26);
    chk("menu re-entered", 32'h1, 32'(MENU_STEP));
    press(0, 26);
    chk("long exit", 32'h0, 32'(MENU_STEP));
    FLOW_CONFIRM_SENSOR_PRESENT <= 1'b1;
    FLOW_CONFIRM_SENSOR_FAULT <= 1'b1;
    cyc(8);
    chk("relay flow disabled", 32'h0, 32'(ALARM_RELAY));
    wb(1'b1, 32'h00000000, 32'h00000008);
    cyc(8);
    chk("relay flow fault", 32'h1, 32'(ALARM_RELAY));
    FLOW_CONFIRM_SENSOR_FAULT <= 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      fire <= 1'b1;
      cyc(1);
      fire <= 1'b0;
      cyc(12);
    end
    wait_run(1'b1, 20);
    chk("live pulse count", 32'h1, 32'(PULSE_COUNT));
    MEMBRANE_RUPTURE_DETECT <= 1'b1;
    wait_run(1'b0, 10);
    cyc(2);
    chk("relay rupture", 32'h1, 32'(ALARM_RELAY));
    chk("rupture flash", 32'h1, 32'(RUPTURE_FLASH));
    MEMBRANE_RUPTURE_DETECT <= 1'b0;
    cyc(4);
    chk("rupture cleared", 32'h0, 32'(RUPTURE_FLASH));
    chk("no restart", 32'h0, 32'(MOTOR_RUN));
    fire <= 1'b1;
    cyc(1);
    fire <= 1'b0;
    wait_run(1'b1, 20);
    wb(1'b1, 32'h00000000, 32'h0000000A);
    wait_run(1'b0, 10);
    finish_test();
  end
endmodule
`default_nettype wire
